// *** include/bssr_map.vh ***
// Function
// - start pointer low five bits index the 32-byte buffer at FF80-FF9F
// - end pointer low five bits index the last buffer byte transferred
// - bytes move continuously over the area from start index to end index
// - equal start and end index moves exactly one byte
// - bits 7 to 5 of all four registers read one, writes ignored
// - start pointer, end pointer and control reset to E0
// - control bit 4 selects receive at 0, transmit at 1
// - gap field stretches clock high by 0, 1, 2 or 8 clock cycles
// - gap stretching applies only with an internal clock source
// - gap divisions fall every 8 or 16 bits per gap interval bit
// - clock select picks system clock over 2, 4, 8 or external clock
// - status resets to E0 or E8, overrun flag undefined
// - after transmit, final bit field holds last bit and drives output pin
// - software writes to final bit field set the output pin level
// - abort by clearing start flag puts new final bit on output at once
// - overrun flag sets on excess data or spurious clock pulses
// - any status write clears overrun and wait violation flags
// - buffer access during transfer is ignored, sets wait flag and interrupt
// - gap interval bit 0 gives 16-bit divisions, 1 gives 8-bit
// - start flag starts transfer, stays set, self-clears; clear aborts
// - start above end wraps from last buffer byte to first
// - lsb first, transmit changes on falling edge, receive samples on rising
`ifndef BSSR_MAP_VH
`define BSSR_MAP_VH

`define BSSR_BUF_BASE     8'h80
`define BSSR_BUF_MASK     8'hE0
`define BSSR_ADDR_XFER_START_POINTER    8'hA0
`define BSSR_ADDR_XFER_END_POINTER    8'hA1
`define BSSR_ADDR_CTRL    8'hA2
`define BSSR_ADDR_STAT    8'hA3
`define BSSR_RSV_ONES     8'hE0
`define BSSR_RST_REG      5'h00
`define BSSR_UNMAPPED     8'hFF
`define BSSR_BUSY_RD      8'hFF

`define BSSR_CTRL_DIR     4
`define BSSR_ST_FINAL     4
`define BSSR_ST_OVR       3
`define BSSR_ST_WT        2
`define BSSR_ST_GIT       1
`define BSSR_ST_STF       0

`define BSSR_CS_DIV2      2'h0
`define BSSR_CS_DIV4      2'h1
`define BSSR_CS_DIV8      2'h2
`define BSSR_CS_EXT       2'h3
`define BSSR_HALF_DIV2    2'h0
`define BSSR_HALF_DIV4    2'h1
`define BSSR_HALF_DIV8    2'h3

`define BSSR_GAP_NONE     2'h0
`define BSSR_GAP_ONE      2'h1
`define BSSR_GAP_TWO      2'h2
`define BSSR_GAP_HALF1    5'h02
`define BSSR_GAP_HALF2    5'h04
`define BSSR_GAP_HALF8    5'h10

`define BSSR_LAST_BIT     3'h7

`endif

// *** core/bssr_buf_mem.v ***
`timescale 1ns/100ps
module bssr_buf_mem (
	input  wire       clk_sys_i,
	input  wire       we_i,
	input  wire [4:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       use_alt_i,
	input  wire [7:0] alt_i,
	output reg  [7:0] rdata_o
);
	reg [7:0] mem [0:31];

	// register reads ride through the same output flop so the bus data is always registered
	always @(posedge clk_sys_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		if (use_alt_i) begin
			rdata_o <= alt_i;
		end else begin
			rdata_o <= mem[addr_i];
		end
	end
endmodule // bssr_buf_mem

// *** core/bssr_core.v ***
`timescale 1ns/100ps
`include "bssr_map.vh"
module bssr_core (
	input  wire       clk_sys_i,
	input  wire       srst_i,
	input  wire [7:0] reg_addr_i,
	input  wire [7:0] reg_wdata_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	output wire [7:0] reg_rdata_o,
	input  wire       serial_clock_pin_i,
	output reg        serial_clock_pin_o,
	output reg        serial_clock_pin_oe_n_o,
	output reg        serial_out_pin_o,
	input  wire       serial_in_pin_i,
	output reg        serial_irq_request_o,
	output reg        xfer_busy_o
);
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_FETCH = 2'h1;
	localparam [1:0] ST_LOAD  = 2'h2;
	localparam [1:0] ST_RUN   = 2'h3;

	reg [1:0] state_q;
	reg [4:0] start_index_q;
	reg [4:0] end_index_q;
	reg       dir_tx_q;
	reg [1:0] gap_len_q;
	reg [1:0] clock_source_q;
	reg       final_tx_bit_q;
	reg       overrun_flag_q;
	reg       wait_violation_flag_q;
	reg       gap_interval_select_q;
	reg [4:0] idx_q;
	reg [7:0] shreg_q;
	reg [2:0] bitn_q;
	reg       division_q;
	reg [4:0] gap_q;
	reg [1:0] presc_q;
	reg       sck_prev_q;
	reg       done_q;

	wire       busy;
	wire       ext_clk;
	wire       hit_buf;
	wire       hit_reg;
	wire       wr_stat;
	wire       buf_violation;
	wire [1:0] half_max;
	wire       tick;
	wire       run;
	wire       fall_ev;
	wire       rise_ev;
	wire       byte_done;
	wire       last_byte;
	wire [7:0] rx_byte;
	wire [7:0] mem_rdata;
	wire [4:0] mem_addr;
	wire       mem_we;
	wire [7:0] mem_wdata;
	wire       gap_due;
	reg  [4:0] gap_half;
	reg  [7:0] reg_rd_val;

	assign busy    = (state_q != ST_IDLE);
	assign ext_clk = (clock_source_q == `BSSR_CS_EXT);
	assign hit_buf = ((reg_addr_i & `BSSR_BUF_MASK) == `BSSR_BUF_BASE);
	assign hit_reg = (reg_addr_i == `BSSR_ADDR_XFER_START_POINTER) || (reg_addr_i == `BSSR_ADDR_XFER_END_POINTER) ||
	                 (reg_addr_i == `BSSR_ADDR_CTRL) || (reg_addr_i == `BSSR_ADDR_STAT);
	assign wr_stat = reg_wr_i && (reg_addr_i == `BSSR_ADDR_STAT);
	assign buf_violation = busy && hit_buf && (reg_wr_i || reg_rd_i);

	// half period of the internal shift clock in system clocks, minus one
	assign half_max = (clock_source_q == `BSSR_CS_DIV2) ? `BSSR_HALF_DIV2 :
	                  (clock_source_q == `BSSR_CS_DIV4) ? `BSSR_HALF_DIV4 :
	                  `BSSR_HALF_DIV8;
	assign run  = (state_q == ST_RUN);
	assign tick = run && !ext_clk && (presc_q == half_max);

	// internal edges come from our own clock flop; external ones from the pin history
	assign fall_ev = run && (ext_clk ? (sck_prev_q && !serial_clock_pin_i) :
	                 (tick && serial_clock_pin_o && (gap_q == `BSSR_RST_REG)));
	assign rise_ev = run && (ext_clk ? (!sck_prev_q && serial_clock_pin_i) :
	                 (tick && !serial_clock_pin_o));

	assign rx_byte   = {serial_in_pin_i, shreg_q[7:1]};
	assign byte_done = rise_ev && (bitn_q == `BSSR_LAST_BIT);
	assign last_byte = (idx_q == end_index_q);

	// a division closes every byte with 8-bit spacing, every second byte with 16-bit
	assign gap_due = !ext_clk && (gap_len_q != `BSSR_GAP_NONE) &&
	                 (gap_interval_select_q || division_q);

	always @* begin
		case (gap_len_q)
			`BSSR_GAP_ONE: begin
				gap_half = `BSSR_GAP_HALF1;
			end
			`BSSR_GAP_TWO: begin
				gap_half = `BSSR_GAP_HALF2;
			end
			default: begin
				gap_half = `BSSR_GAP_HALF8;
			end
		endcase
	end

	// the engine owns the buffer port while busy; the bus cannot reach it then
	assign mem_addr  = busy ? idx_q : reg_addr_i[4:0];
	assign mem_we    = busy ? (byte_done && !dir_tx_q) : (reg_wr_i && hit_buf);
	assign mem_wdata = busy ? rx_byte : reg_wdata_i;

	always @* begin
		case (reg_addr_i)
			`BSSR_ADDR_XFER_START_POINTER: begin
				reg_rd_val = `BSSR_RSV_ONES | {3'h0, start_index_q};
			end
			`BSSR_ADDR_XFER_END_POINTER: begin
				reg_rd_val = `BSSR_RSV_ONES | {3'h0, end_index_q};
			end
			`BSSR_ADDR_CTRL: begin
				reg_rd_val = `BSSR_RSV_ONES | {3'h0, dir_tx_q, gap_len_q, clock_source_q};
			end
			`BSSR_ADDR_STAT: begin
				reg_rd_val = `BSSR_RSV_ONES | {3'h0, final_tx_bit_q, overrun_flag_q,
				             wait_violation_flag_q, gap_interval_select_q, busy};
			end
			default: begin
				reg_rd_val = hit_buf ? `BSSR_BUSY_RD : `BSSR_UNMAPPED;
			end
		endcase
	end

	bssr_buf_mem u_mem (
		.clk_sys_i (clk_sys_i),
		.we_i      (mem_we),
		.addr_i    (mem_addr),
		.wdata_i   (mem_wdata),
		.use_alt_i (reg_rd_i && (hit_reg || !hit_buf || busy)),
		.alt_i     (reg_rd_val),
		.rdata_o   (mem_rdata)
	);

	assign reg_rdata_o = mem_rdata;

	// software-written configuration
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			start_index_q         <= `BSSR_RST_REG;
			end_index_q           <= `BSSR_RST_REG;
			dir_tx_q              <= 1'b0;
			gap_len_q             <= `BSSR_GAP_NONE;
			clock_source_q        <= `BSSR_CS_DIV2;
			gap_interval_select_q <= 1'b0;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `BSSR_ADDR_XFER_START_POINTER) begin
				start_index_q <= reg_wdata_i[4:0];
			end
			if (reg_addr_i == `BSSR_ADDR_XFER_END_POINTER) begin
				end_index_q <= reg_wdata_i[4:0];
			end
			if (reg_addr_i == `BSSR_ADDR_CTRL) begin
				dir_tx_q       <= reg_wdata_i[`BSSR_CTRL_DIR];
				gap_len_q      <= reg_wdata_i[3:2];
				clock_source_q <= reg_wdata_i[1:0];
			end
			if (wr_stat) begin
				gap_interval_select_q <= reg_wdata_i[`BSSR_ST_GIT];
			end
		end
	end

	// status flags; a hardware set in the same cycle as a clearing write wins
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			overrun_flag_q        <= 1'b0;
			wait_violation_flag_q <= 1'b0;
		end else begin
			if (wr_stat) begin
				overrun_flag_q        <= 1'b0;
				wait_violation_flag_q <= 1'b0;
			end
			if (buf_violation) begin
				wait_violation_flag_q <= 1'b1;
			end
			// external edges outside the shifting window mean extra pulses or excess data
			if (ext_clk && (sck_prev_q ^ serial_clock_pin_i) &&
			    (done_q || state_q == ST_FETCH || state_q == ST_LOAD)) begin
				overrun_flag_q <= 1'b1;
			end
		end
	end

	// transfer engine
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_q              <= ST_IDLE;
			idx_q                <= `BSSR_RST_REG;
			shreg_q              <= 8'h00;
			bitn_q               <= 3'h0;
			division_q           <= 1'b0;
			gap_q                <= `BSSR_RST_REG;
			presc_q              <= 2'h0;
			done_q               <= 1'b0;
			final_tx_bit_q       <= 1'b0;
			serial_out_pin_o     <= 1'b0;
			serial_clock_pin_o   <= 1'b1;
			serial_irq_request_o <= 1'b0;
		end else begin
			serial_irq_request_o <= buf_violation;
			if (wr_stat) begin
				final_tx_bit_q   <= reg_wdata_i[`BSSR_ST_FINAL];
				serial_out_pin_o <= reg_wdata_i[`BSSR_ST_FINAL];
			end
			if (run && !ext_clk) begin
				presc_q <= tick ? 2'h0 : presc_q + 2'h1;
			end else begin
				presc_q <= 2'h0;
			end
			case (state_q)
				ST_IDLE: begin
					serial_clock_pin_o <= 1'b1;
					if (wr_stat && reg_wdata_i[`BSSR_ST_STF]) begin
						idx_q      <= start_index_q;
						bitn_q     <= 3'h0;
						division_q <= 1'b0;
						gap_q      <= `BSSR_RST_REG;
						done_q     <= 1'b0;
						state_q    <= dir_tx_q ? ST_FETCH : ST_RUN;
					end
				end
				ST_FETCH: begin
					// a register read in this cycle takes the shared read flop, so retry
					if (!reg_rd_i) begin
						state_q <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					shreg_q <= mem_rdata;
					state_q <= ST_RUN;
				end
				ST_RUN: begin
					if (tick) begin
						if (gap_q != `BSSR_RST_REG) begin
							gap_q <= gap_q - 5'h01;
						end else begin
							serial_clock_pin_o <= !serial_clock_pin_o;
						end
					end
					if (fall_ev && dir_tx_q) begin
						serial_out_pin_o <= shreg_q[0];
						shreg_q          <= {1'b0, shreg_q[7:1]};
					end
					if (rise_ev) begin
						bitn_q <= bitn_q + 3'h1;
						if (!dir_tx_q) begin
							shreg_q <= rx_byte;
						end
					end
					if (byte_done) begin
						division_q <= !division_q;
						if (last_byte) begin
							state_q              <= ST_IDLE;
							done_q               <= 1'b1;
							serial_irq_request_o <= 1'b1;
							if (dir_tx_q) begin
								final_tx_bit_q <= serial_out_pin_o;
							end
						end else begin
							idx_q   <= idx_q + 5'h01;
							state_q <= dir_tx_q ? ST_FETCH : ST_RUN;
							if (gap_due) begin
								gap_q <= gap_half;
							end
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
			// clearing the start flag mid-transfer aborts; buffer and settings are kept
			if (busy && wr_stat && !reg_wdata_i[`BSSR_ST_STF]) begin
				state_q            <= ST_IDLE;
				gap_q              <= `BSSR_RST_REG;
				bitn_q             <= 3'h0;
				serial_clock_pin_o <= 1'b1;
			end
		end
	end

	// pin direction and history
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			serial_clock_pin_oe_n_o <= 1'b0;
			sck_prev_q              <= 1'b1;
			xfer_busy_o             <= 1'b0;
		end else begin
			serial_clock_pin_oe_n_o <= ext_clk;
			sck_prev_q              <= serial_clock_pin_i;
			xfer_busy_o             <= busy;
		end
	end
endmodule // bssr_core

// *** tb/bssr_chk_assertions.sv ***
`timescale 1ns/100ps
module bssr_chk (
	input wire       clk_sys_i,
	input wire       srst_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire       reg_wr_i,
	input wire       reg_rd_i,
	input wire [7:0] reg_rdata_o,
	input wire       serial_clock_pin_o,
	input wire       serial_clock_pin_oe_n_o,
	input wire       serial_out_pin_o,
	input wire       serial_irq_request_o,
	input wire       xfer_busy_o
);
	reg [1:0] cs_q;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	// clock select is shadowed from bus writes so divider checks need no internal access
	always @(posedge clk_sys_i) begin
		if (srst_i)
			cs_q <= 2'h0;
		else if (reg_wr_i && reg_addr_i == 8'hA2)
			cs_q <= reg_wdata_i[1:0];
	end
	reset_idle_a: assert property (disable iff (1'b0) srst_i |=> serial_clock_pin_o && !xfer_busy_o)
		else $error("not idle after reset");
	start_busy_a: assert property (reg_wr_i && reg_addr_i == 8'hA3 && reg_wdata_i[0] && !xfer_busy_o
		|-> ##2 xfer_busy_o) else $error("start did not set busy");
	data_fall_a: assert property ($changed(serial_out_pin_o) && $past(xfer_busy_o) && !$past(reg_wr_i)
		&& !$past(reg_wr_i, 2) |-> $fell(serial_clock_pin_o)) else $error("data moved off fall");
	div2_low_a: assert property (cs_q == 2'h0 && $fell(serial_clock_pin_o) |=> serial_clock_pin_o)
		else $error("low phase wrong for divide by 2");
	div8_low_a: assert property (cs_q == 2'h2 && $fell(serial_clock_pin_o)
		|=> !serial_clock_pin_o [*3] ##1 serial_clock_pin_o) else $error("low phase wrong");
	rsv_ones_a: assert property ($past(reg_rd_i) && $past(reg_addr_i[7:2]) == 6'h28
		|-> reg_rdata_o[7:5] == 3'h7) else $error("reserved bits not one");
	busy_read_a: assert property ($past(reg_rd_i) && $past(reg_addr_i[7:5]) == 3'h4 && xfer_busy_o
		&& $past(xfer_busy_o) |-> reg_rdata_o == 8'hFF) else $error("buffer read while busy");
	busy_irq_a: assert property ($past(reg_rd_i || reg_wr_i) && $past(reg_addr_i[7:5]) == 3'h4
		&& xfer_busy_o && $past(xfer_busy_o) |-> ##[0:1] serial_irq_request_o) else $error("no irq");
	pin_dir_a: assert property (cs_q == $past(cs_q)
		|-> serial_clock_pin_oe_n_o == (cs_q == 2'h3)) else $error("clock pin direction");
endmodule // bssr_chk
bind bssr_core bssr_chk u_chk (.*);

// *** tb/bssr_peer.sv ***
`timescale 1ns/100ps
module bssr_peer (
	input  wire clk_sys_i,
	input  wire sck_i,
	input  wire so_i,
	input  wire busy_i,
	output reg  si_o
);
	reg [7:0] rx_mem [0:31];
	reg [7:0] tx_mem [0:31];
	integer   rx_bit;
	integer   tx_bit;
	initial begin
		si_o = 1'b0;
		rx_bit = 0;
		tx_bit = 0;
	end
	// next bit leaves on the fall so it is settled well before the sampling rise
	always @(negedge sck_i) begin
		// scheduled after the idle toggle of the same edge, so the data bit wins
		si_o <= rx_mem[(rx_bit / 8) % 32][rx_bit % 8];
		rx_bit = rx_bit + 1;
	end
	always @(posedge sck_i) begin
		tx_mem[(tx_bit / 8) % 32][tx_bit % 8] = so_i;
		tx_bit = tx_bit + 1;
	end
	// outside a transfer the line carries nothing, so it keeps toggling
	always @(posedge clk_sys_i)
		if (!busy_i)
			si_o <= ~si_o;
endmodule // bssr_peer

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	reg        clk_sys_i;
	reg        srst_i;
	reg  [7:0] a_q;
	reg  [7:0] wd_q;
	reg        wr_q;
	reg        rd_q;
	reg        ext_sck;
	wire [7:0] rdat;
	wire       sck;
	wire       oe_n;
	wire       so;
	wire       si;
	wire       irq;
	wire       busy;
	integer    err_count;
	integer    n_compared;
	integer    irqs;
	integer    i;
	integer    j;
	integer    k;
	integer    n;
	reg  [7:0] v;
	reg  [7:0] mem [0:31];
	bssr_core dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(a_q), .reg_wdata_i(wd_q),
		.reg_wr_i(wr_q), .reg_rd_i(rd_q), .reg_rdata_o(rdat), .serial_clock_pin_i(ext_sck),
		.serial_clock_pin_o(sck), .serial_clock_pin_oe_n_o(oe_n), .serial_out_pin_o(so),
		.serial_in_pin_i(si), .serial_irq_request_o(irq), .xfer_busy_o(busy));
	bssr_peer peer (.clk_sys_i(clk_sys_i), .sck_i(sck), .so_i(so), .busy_i(busy), .si_o(si));
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i)
		if (irq === 1'b1)
			irqs <= irqs + 1;
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_sys_i);
			a_q <= a;
			wd_q <= d;
			wr_q <= 1'b1;
			@(posedge clk_sys_i);
			wr_q <= 1'b0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(posedge clk_sys_i);
			a_q <= a;
			rd_q <= 1'b1;
			@(posedge clk_sys_i);
			rd_q <= 1'b0;
			#1 v = rdat;
		end
	endtask
	task chk(input [63:0] what, input [15:0] e, input [15:0] g);
		begin
			n_compared = n_compared + 1;
			if (g !== e) begin
				err_count = err_count + 1;
				$display("Error %0s expected %h seen %h", what, e, g);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_count);
			if (err_count == 0 && n_compared > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task xfer(input dir, input [4:0] s, input [4:0] e, input [1:0] cs, input ab);
		begin
			for (i = 0; i < 32; i = i + 1) begin
				mem[i] = $urandom;
				peer.rx_mem[i] = $urandom;
				wr(8'h80 + i[7:0], mem[i]);
			end
			wr(8'hA0, {3'h0, s});
			wr(8'hA1, {3'h0, e});
			wr(8'hA2, {3'h0, dir, s[1:0], cs});
			peer.rx_bit = 0;
			peer.tx_bit = 0;
			irqs = 0;
			wr(8'hA3, {6'h00, e[0], 1'b1});
			n = ((e - s) & 31) + 1;
			repeat (3) @(posedge clk_sys_i);
			#1 k = 0;
			if (ab) begin
				repeat (300) @(posedge clk_sys_i);
				rd(8'h9F);
				chk("busy_rd", 8'hFF, v);
				wr(8'h9F, ~mem[31]);
				rd(8'hA3);
				chk("wait", 8'h05, v & 8'h0D);
				chk("irqs", 2, irqs);
				// abort is allowed here: the unit receives, nothing is being sent
				wr(8'hA3, 8'h10);
				repeat (2) @(posedge clk_sys_i);
				#1 chk("abort", 2'h1, {busy, so});
				rd(8'hA3);
				chk("clear", 8'hF0, v);
				rd(8'h9F);
				chk("intact", mem[31], v);
			end else begin
				while (busy !== 1'b0 && k < 20000) begin
					@(posedge clk_sys_i);
					#1 k = k + 1;
				end
				if (k == 20000) begin
					err_count = err_count + 1;
					give_verdict;
				end
				chk("bits", n * 8, peer.tx_bit);
				chk("irqs", 1, irqs);
				for (k = 0; k < n; k = k + 1)
					if (dir)
						chk("tx_byte", mem[(s + k) % 32], peer.tx_mem[k]);
					else
						mem[(s + k) % 32] = peer.rx_mem[k];
				for (i = 0; i < 32; i = i + 1) begin
					rd(8'h80 + i[7:0]);
					chk("buffer", mem[i], v);
				end
				rd(8'hA3);
				if (dir)
					chk("final", {2{mem[e][7]}}, {v[4], so});
			end
			$display("transfer %0d to %0d done", s, e);
		end
	endtask
	initial begin
		srst_i = 1'b1;
		a_q = 8'h00;
		wd_q = 8'h00;
		wr_q = 1'b0;
		rd_q = 1'b0;
		ext_sck = 1'b1;
		err_count = 0;
		n_compared = 0;
		irqs = 0;
		v = $urandom(69);
		repeat (5) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		for (j = 0; j < 4; j = j + 1) begin
			rd(8'hA0 + j[7:0]);
			chk("reset", 8'hE0, v);
		end
		rd(8'hA7);
		chk("unmapped", 8'hFF, v);
		for (j = 0; j < 3; j = j + 1) begin
			n = $urandom;
			wr(8'hA0 + j[7:0], n[7:0]);
			rd(8'hA0 + j[7:0]);
			chk("reg_rw", n[7:0] | 8'hE0, v);
		end
		wr(8'hA2, 8'h03);
		repeat (2) @(posedge clk_sys_i);
		#1 chk("pin_dir", 1, oe_n);
		n = $urandom & 8'hFE;
		wr(8'hA3, n[7:0]);
		rd(8'hA3);
		chk("status", {3'h7, n[4], 2'h0, n[1], 1'b0, n[4]}, {v, so});
		$display("registers done");
		xfer(1'b1, 5'h03, 5'h03, 2'h0, 1'b0);
		xfer(1'b1, 5'h1E, 5'h01, 2'h1, 1'b0);
		xfer(1'b0, 5'h1D, 5'h02, 2'h2, 1'b0);
		for (j = 0; j < 4; j = j + 1)
			xfer($urandom, $urandom, $urandom, $urandom % 3, 1'b0);
		// a stray external clock pulse after completion counts as overrun
		wr(8'hA2, 8'h03);
		@(posedge clk_sys_i);
		ext_sck <= 1'b0;
		@(posedge clk_sys_i);
		ext_sck <= 1'b1;
		rd(8'hA3);
		chk("overrun", 8'h08, v & 8'h08);
		wr(8'hA3, 8'h00);
		rd(8'hA3);
		chk("ovr_clear", 8'h00, v & 8'h0C);
		$display("overrun done");
		xfer(1'b0, 5'h00, 5'h1F, 2'h0, 1'b1);
		give_verdict;
	end
endmodule // testbench
